// File: hdl/sscs_cfg.svh
// Register offsets, field positions, reset values and timing constants of the sequencer.
`ifndef SSCS_CFG_SVH
`define SSCS_CFG_SVH

`define SSCS_ADDR_CTRL_A 5'h00
`define SSCS_ADDR_CTRL_B 5'h01
`define SSCS_ADDR_PHASE 5'h02
`define SSCS_ADDR_SENSOR 5'h03
`define SSCS_ADDR_WEIGHT 5'h04
`define SSCS_ADDR_DEMAG_CMP 5'h05
`define SSCS_ADDR_ZERO_CMP 5'h06
`define SSCS_ADDR_BLANK 5'h07
`define SSCS_ADDR_PRESC 5'h08
`define SSCS_ADDR_STATUS 5'h09
`define SSCS_ADDR_TIMER 5'h0A
`define SSCS_ADDR_ZCAP 5'h0B
`define SSCS_ADDR_DELAY 5'h0C
`define SSCS_ADDR_PERIOD 5'h0D
`define SSCS_ADDR_REP 5'h0E
`define SSCS_ADDR_CMP_U 5'h0F
`define SSCS_ADDR_CMP_V 5'h10
`define SSCS_ADDR_CMP_W 5'h11
`define SSCS_ADDR_DEADTIME 5'h12
`define SSCS_ADDR_SWC 5'h13

`define SSCS_A_RUN 0
`define SSCS_A_SENSOR 1
`define SSCS_A_SINE 2
`define SSCS_A_SIM_D 3
`define SSCS_A_SIM_Z 4
`define SSCS_A_WIDE 5
`define SSCS_B_POL 0
`define SSCS_B_SWAP 1
`define SSCS_ST_Z 4
`define SSCS_ST_C 5
`define SSCS_ST_D 6
`define SSCS_ST_U 7
`define SSCS_ST_CAP 8

`define SSCS_HIGH_MASK 6'h2A
`define SSCS_LOW_MASK 6'h15
`define SSCS_RST_BLANK 16'h00C8
`define SSCS_RST_PERIOD 12'hFFF
`define SSCS_RST_WEIGHT 8'h80
`define SSCS_RST_SIMCMP 16'hFFFF
`define SSCS_PRESC_MAX 4'hF
`define SSCS_SPEED_NONE 2'h0
`define SSCS_ACCEL_EN 1
`define SSCS_ACCEL_HIGH 0

`endif

// File: hdl/sscs_pkg.sv
// Types shared by the sequencer modules.
package sscs_pkg;
	typedef enum logic [3:0] {
		SSCS_IDLE = 4'h1,
		SSCS_DEMAG = 4'h2,
		SSCS_ZWAIT = 4'h4,
		SSCS_DELAY = 4'h8
	} sscs_state_t;
	typedef logic [11:0] sscs_cmp_t;
endpackage

// File: hdl/sscs_pwm_if.sv
// Link between the sequencer core and the three-phase PWM generator.
`timescale 1ns/1ns
`default_nettype none
interface sscs_pwm_if;
	import sscs_pkg::*;
	logic enable;
	sscs_cmp_t period;
	logic [7:0] rep;
	sscs_cmp_t [2:0] cmp_pre;
	logic [2:0] raw;
	logic update;
	modport gen (input enable, input period, input rep, input cmp_pre, output raw, output update);
	modport core (output enable, output period, output rep, output cmp_pre, input raw, input update);
endinterface
`default_nettype wire

// File: hdl/sscs_pwm_gen.sv
// Three-phase PWM generator with repetition counter and preloaded compares.
`timescale 1ns/1ns
`default_nettype none
module sscs_pwm_gen
	import sscs_pkg::*;
(
	input wire logic clk, // Peripheral clock.
	input wire logic nrst, // Synchronous reset, active low.
	sscs_pwm_if.gen pwm // Settings in, raw phases and update out.
);
	sscs_cmp_t cnt_reg;
	logic [7:0] rep_reg;
	sscs_cmp_t [2:0] act_reg;
	logic wrap;
	logic upd;

	assign wrap = pwm.enable && (cnt_reg >= pwm.period);
	assign upd = wrap && (rep_reg == 8'h00);
	assign pwm.update = upd;

	// ***************************************
	// Counter and repetition counter
	// ***************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_reg <= 12'h000;
			rep_reg <= 8'h00;
		end else if (!pwm.enable) begin
			cnt_reg <= 12'h000;
			rep_reg <= pwm.rep;
		end else if (wrap) begin
			cnt_reg <= 12'h000;
			rep_reg <= upd ? pwm.rep : rep_reg - 8'h01;
		end else begin
			cnt_reg <= cnt_reg + 12'h001;
		end
	end

	// ***************************************
	// Active compares and raw outputs
	// ***************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			act_reg <= '0;
		end else if (upd || !pwm.enable) begin
			act_reg <= pwm.cmp_pre;
		end
	end

	// A compare of zero gives 0 %, one above the period gives 100 %.
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_ch
			assign pwm.raw[i] = pwm.enable && (cnt_reg < act_reg[i]);
		end
	endgenerate
endmodule
`default_nettype wire

// File: hdl/sscs_top.sv
// Six-step commutation sequencer with sine PWM and speed measurement.
`timescale 1ns/1ns
`default_nettype none
`include "sscs_cfg.svh"
module sscs_top
	import sscs_pkg::*;
#(
	parameter int DT_W = 8 // Deadtime counter width.
) (
	input wire logic clk, // Peripheral clock, 250 MHz.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic [4:0] addr, // Register address.
	input wire logic [15:0] wdata, // Write data.
	input wire logic wr, // Write strobe.
	input wire logic rd, // Read strobe.
	output logic [15:0] rdata, // Read data, cycle after rd.
	input wire logic cmp_in, // Analog comparator result.
	input wire logic phase_input_a, // Phase input A, digital view.
	input wire logic phase_input_b, // Phase input B, digital view.
	input wire logic phase_input_c, // Phase input C, digital view.
	output logic [1:0] comparator_input_select, // Analog mux select.
	output logic digital_input_mode, // High: phase pins used as digital.
	output logic [5:0] phase_out, // Six switch drive outputs.
	output logic commutate, // Commutation event pulse.
	output logic update_irq // PWM update interrupt pulse.
);
	logic [7:0] control_reg_a;
	logic [3:0] control_reg_b;
	logic [7:0] phase_state_reg;
	logic [1:0] sensor_config_reg;
	logic [7:0] weight_reg;
	logic [15:0] demag_cmp_reg;
	logic [15:0] zero_cmp_reg;
	logic [15:0] blank_len_reg;
	logic [3:0] presc_reg;
	logic [8:4] flag_reg;
	logic [15:0] timer_reg;
	logic [15:0] zcap_reg;
	logic [7:0] delay_reg;
	sscs_cmp_t period_reg;
	logic [7:0] rep_reg;
	sscs_cmp_t [2:0] cmp_pre_reg;
	logic [DT_W-1:0] deadtime_reg;
	logic [15:0] rdata_reg;
	logic [15:0] presc_cnt_reg;
	logic [15:0] blank_cnt_reg;
	logic src_prev_reg;
	logic [5:0] phase_out_reg;
	sscs_state_t state_reg;
	sscs_state_t state_next;

	sscs_pwm_if pwm_bus ();

	sscs_pwm_gen u_pwm (
		.clk(clk),
		.nrst(nrst),
		.pwm(pwm_bus.gen)
	);

	// ***************************************
	// Decoding and mode selection
	// ***************************************
	logic run;
	logic sensor_mode_bit;
	logic sine_mode;
	logic speed_mode;
	logic [5:0] output_pattern;
	logic edge_polarity_bit;
	logic zero_demag_swap_bit;
	logic [1:0] demag_accel_select;
	logic [1:0] speed_sensor_type;
	logic swc_wr;
	logic status_wr;

	assign run = control_reg_a[`SSCS_A_RUN];
	assign sensor_mode_bit = control_reg_a[`SSCS_A_SENSOR];
	assign sine_mode = control_reg_a[`SSCS_A_SINE];
	assign output_pattern = phase_state_reg[5:0];
	assign comparator_input_select = phase_state_reg[7:6];
	assign edge_polarity_bit = control_reg_b[`SSCS_B_POL];
	assign zero_demag_swap_bit = control_reg_b[`SSCS_B_SWAP];
	assign demag_accel_select = control_reg_b[3:2];
	assign speed_sensor_type = sensor_config_reg;
	assign speed_mode = (speed_sensor_type != `SSCS_SPEED_NONE);
	assign digital_input_mode = speed_mode;
	assign swc_wr = wr && (addr == `SSCS_ADDR_SWC) && wdata[0];
	assign status_wr = wr && (addr == `SSCS_ADDR_STATUS);

	// ***************************************
	// Detection source and edge classing
	// ***************************************
	logic src;
	logic rise;
	logic fall;
	logic z_rising;
	logic z_edge;
	logic d_edge;
	logic meas_window;

	// Speed mode looks at pin A directly, the other modes at the comparator.
	assign src = speed_mode ? phase_input_a : cmp_in;
	assign rise = src && !src_prev_reg;
	assign fall = !src && src_prev_reg;
	assign z_rising = edge_polarity_bit ^ zero_demag_swap_bit;
	assign z_edge = z_rising ? rise : fall;
	assign d_edge = z_rising ? fall : rise;
	// In six-step mode, outside low-side demagnetization acceleration, high-side PWM is off whenever phase U raw modulation is low.
	assign meas_window = !pwm_bus.raw[0];

	// ***************************************
	// Timer, prescaler and multiplier
	// ***************************************
	logic [15:0] presc_mask;
	logic tick;
	logic [15:0] timer_inc;
	logic timer_top;
	logic [15:0] product;

	assign presc_mask = (16'h0001 << presc_reg) - 16'h0001;
	assign tick = ((presc_cnt_reg & presc_mask) == presc_mask);
	assign timer_inc = control_reg_a[`SSCS_A_WIDE] ? timer_reg + 16'h0001 :
		{8'h00, timer_reg[7:0] + 8'h01};
	assign timer_top = control_reg_a[`SSCS_A_WIDE] ? (timer_reg == 16'hFFFF) :
		(timer_reg[7:0] == 8'hFF);

	// ***************************************
	// Event sequencer
	// ***************************************
	logic active;
	logic blank_done;
	logic d_event;
	logic z_event;
	logic c_hw;
	logic c_event;
	logic cap_event;
	logic [7:0] mul_src;

	assign active = run && !speed_mode && !sine_mode;
	// Blanking is only applied in sensorless operation.
	assign blank_done = sensor_mode_bit || (blank_cnt_reg == 16'h0000);
	assign d_event = (state_reg == SSCS_DEMAG) && blank_done && (d_edge ||
		(control_reg_a[`SSCS_A_SIM_D] && timer_reg >= demag_cmp_reg));
	assign z_event = (state_reg == SSCS_ZWAIT) && ((z_edge && meas_window) ||
		(control_reg_a[`SSCS_A_SIM_Z] && timer_reg >= zero_cmp_reg));
	assign c_hw = (state_reg == SSCS_DELAY) && (timer_reg[7:0] >= delay_reg);
	assign c_event = active && (c_hw || swc_wr);
	assign cap_event = run && speed_mode && rise;
	assign commutate = c_event;
	// A fresh capture feeds the multiplier at once, so the delay never lags one step behind.
	assign mul_src = (z_event || cap_event) ? timer_reg[7:0] : zcap_reg[7:0];
	assign product = mul_src * weight_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SSCS_IDLE: begin
				if (active) begin
					state_next = SSCS_DEMAG;
				end
			end
			SSCS_DEMAG: begin
				if (d_event) begin
					state_next = SSCS_ZWAIT;
				end
			end
			SSCS_ZWAIT: begin
				if (z_event) begin
					state_next = SSCS_DELAY;
				end
			end
			SSCS_DELAY: begin
				if (c_hw) begin
					state_next = SSCS_DEMAG;
				end
			end
			default: begin
				state_next = SSCS_IDLE;
			end
		endcase
		if (!active) begin
			state_next = SSCS_IDLE;
		end else if (swc_wr) begin
			state_next = SSCS_DEMAG;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= SSCS_IDLE;
			src_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			src_prev_reg <= src;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			blank_cnt_reg <= 16'h0000;
		end else if (c_event || (state_reg == SSCS_IDLE)) begin
			blank_cnt_reg <= blank_len_reg;
		end else if (blank_cnt_reg != 16'h0000) begin
			blank_cnt_reg <= blank_cnt_reg - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			presc_cnt_reg <= 16'h0000;
			timer_reg <= 16'h0000;
		end else begin
			presc_cnt_reg <= presc_cnt_reg + 16'h0001;
			if (z_event || c_event || cap_event || !run) begin
				timer_reg <= 16'h0000;
				presc_cnt_reg <= 16'h0000;
			end else if (tick && !timer_top) begin
				timer_reg <= timer_inc;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			zcap_reg <= 16'h0000;
			delay_reg <= 8'h00;
		end else begin
			if (z_event || cap_event) begin
				zcap_reg <= timer_reg;
			end
			delay_reg <= product[15:8];
		end
	end

	// ***************************************
	// Sticky event flags, set wins over clear
	// ***************************************
	logic [8:4] flag_set;

	assign flag_set = {cap_event, pwm_bus.update, d_event, c_event, z_event};
	assign update_irq = pwm_bus.update;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= (flag_reg & ~(status_wr ? wdata[8:4] : 5'h00)) | flag_set;
		end
	end

	// ***************************************
	// Deadtime insertion per sine channel
	// ***************************************
	logic [2:0] dt_prev_reg;
	logic [DT_W-1:0] dt_cnt_reg [3];
	logic [5:0] sine_out;

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_dt
			always_ff @(posedge clk) begin
				if (!nrst) begin
					dt_prev_reg[i] <= 1'b0;
					dt_cnt_reg[i] <= '0;
				end else if (pwm_bus.raw[i] != dt_prev_reg[i]) begin
					dt_prev_reg[i] <= pwm_bus.raw[i];
					dt_cnt_reg[i] <= deadtime_reg;
				end else if (dt_cnt_reg[i] != '0) begin
					dt_cnt_reg[i] <= dt_cnt_reg[i] - DT_W'(1);
				end
			end
			assign sine_out[2*i+1] = dt_prev_reg[i] && (dt_cnt_reg[i] == '0);
			assign sine_out[2*i] = !dt_prev_reg[i] && (dt_cnt_reg[i] == '0);
		end
	endgenerate

	// ***************************************
	// Output channel selection
	// ***************************************
	logic [5:0] pwm_side;
	logic [5:0] six_out;

	// During demagnetization the PWM may move to the low side to speed it up.
	assign pwm_side = (state_reg == SSCS_DEMAG && demag_accel_select[`SSCS_ACCEL_EN] &&
		!demag_accel_select[`SSCS_ACCEL_HIGH]) ? `SSCS_LOW_MASK : `SSCS_HIGH_MASK;
	assign six_out = output_pattern & (~pwm_side | {6{pwm_bus.raw[0]}});

	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_out_reg <= 6'h00;
		end else if (!run) begin
			phase_out_reg <= 6'h00;
		end else begin
			phase_out_reg <= sine_mode ? sine_out : six_out;
		end
	end
	assign phase_out = phase_out_reg;

	assign pwm_bus.enable = run && (sine_mode || !speed_mode);
	assign pwm_bus.period = period_reg;
	assign pwm_bus.rep = rep_reg;
	assign pwm_bus.cmp_pre = cmp_pre_reg;

	// ***************************************
	// Register writes
	// ***************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			control_reg_a <= 8'h00;
			control_reg_b <= 4'h0;
			phase_state_reg <= 8'h00;
			sensor_config_reg <= 2'h0;
			weight_reg <= `SSCS_RST_WEIGHT;
			demag_cmp_reg <= `SSCS_RST_SIMCMP;
			zero_cmp_reg <= `SSCS_RST_SIMCMP;
			blank_len_reg <= `SSCS_RST_BLANK;
			period_reg <= `SSCS_RST_PERIOD;
			rep_reg <= 8'h00;
			cmp_pre_reg <= '0;
			deadtime_reg <= '0;
		end else if (wr) begin
			case (addr)
				`SSCS_ADDR_CTRL_A: control_reg_a <= wdata[7:0];
				`SSCS_ADDR_CTRL_B: control_reg_b <= wdata[3:0];
				`SSCS_ADDR_PHASE: phase_state_reg <= wdata[7:0];
				`SSCS_ADDR_SENSOR: sensor_config_reg <= wdata[1:0];
				`SSCS_ADDR_WEIGHT: weight_reg <= wdata[7:0];
				`SSCS_ADDR_DEMAG_CMP: demag_cmp_reg <= wdata;
				`SSCS_ADDR_ZERO_CMP: zero_cmp_reg <= wdata;
				`SSCS_ADDR_BLANK: blank_len_reg <= wdata;
				`SSCS_ADDR_PERIOD: period_reg <= wdata[11:0];
				`SSCS_ADDR_REP: rep_reg <= wdata[7:0];
				`SSCS_ADDR_CMP_U: cmp_pre_reg[0] <= wdata[11:0];
				`SSCS_ADDR_CMP_V: cmp_pre_reg[1] <= wdata[11:0];
				`SSCS_ADDR_CMP_W: cmp_pre_reg[2] <= wdata[11:0];
				`SSCS_ADDR_DEADTIME: deadtime_reg <= wdata[DT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// The prescaler rises by itself, up to 15, whenever a speed capture overflows the timer.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			presc_reg <= 4'h0;
		end else if (wr && addr == `SSCS_ADDR_PRESC) begin
			presc_reg <= wdata[3:0];
		end else if (run && speed_mode && tick && timer_top && presc_reg != `SSCS_PRESC_MAX) begin
			presc_reg <= presc_reg + 4'h1;
		end
	end

	// ***************************************
	// Register reads
	// ***************************************
	logic [15:0] rd_mux;

	always_comb begin
		rd_mux = 16'h0000;
		case (addr)
			`SSCS_ADDR_CTRL_A: rd_mux = {8'h00, control_reg_a};
			`SSCS_ADDR_CTRL_B: rd_mux = {12'h000, control_reg_b};
			`SSCS_ADDR_PHASE: rd_mux = {8'h00, phase_state_reg};
			`SSCS_ADDR_SENSOR: rd_mux = {14'h0000, sensor_config_reg};
			`SSCS_ADDR_WEIGHT: rd_mux = {8'h00, weight_reg};
			`SSCS_ADDR_DEMAG_CMP: rd_mux = demag_cmp_reg;
			`SSCS_ADDR_ZERO_CMP: rd_mux = zero_cmp_reg;
			`SSCS_ADDR_BLANK: rd_mux = blank_len_reg;
			`SSCS_ADDR_PRESC: rd_mux = {12'h000, presc_reg};
			`SSCS_ADDR_STATUS: rd_mux = {7'h00, flag_reg, state_reg};
			`SSCS_ADDR_TIMER: rd_mux = timer_reg;
			`SSCS_ADDR_ZCAP: rd_mux = zcap_reg;
			`SSCS_ADDR_DELAY: rd_mux = {8'h00, delay_reg};
			`SSCS_ADDR_PERIOD: rd_mux = {4'h0, period_reg};
			`SSCS_ADDR_REP: rd_mux = {8'h00, rep_reg};
			`SSCS_ADDR_CMP_U: rd_mux = {4'h0, cmp_pre_reg[0]};
			`SSCS_ADDR_CMP_V: rd_mux = {4'h0, cmp_pre_reg[1]};
			`SSCS_ADDR_CMP_W: rd_mux = {4'h0, cmp_pre_reg[2]};
			`SSCS_ADDR_DEADTIME: rd_mux = 16'(deadtime_reg);
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rd ? rd_mux : 16'h0000;
		end
	end
	assign rdata = rdata_reg;
endmodule
`default_nettype wire

// File: verification/sscs_motor_model.sv
// Behavioural inverter stage and motor: back-EMF comparator and speed pins.
`timescale 1ns/1ns
`default_nettype none
module sscs_motor_model (
	input wire logic clk, // Clock.
	input wire logic nrst, // Reset, active low.
	input wire logic [5:0] phase_out, // Switch drives.
	input wire logic [15:0] half_period, // Cycles between edges less one, 0 stops.
	output logic cmp_in, // Comparator result.
	output logic phase_input_a, // Tacho or encoder A.
	output logic phase_input_b, // Encoder B.
	output logic phase_input_c // Unused phase pin.
);
	logic [15:0] cnt_reg;
	logic bemf_reg;
	logic tacho_reg;
	logic hit;
	assign hit = half_period != 16'h0000 && cnt_reg == half_period;
	// The back-EMF only swings while some winding is powered.
	always_ff @(posedge clk) begin
		if (!nrst || cnt_reg >= half_period) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
		if (!nrst) begin
			bemf_reg <= 1'b0;
			tacho_reg <= 1'b0;
		end else if (hit) begin
			bemf_reg <= bemf_reg ^ (phase_out != 6'h00);
			tacho_reg <= !tacho_reg;
		end
	end
	assign cmp_in = bemf_reg;
	assign phase_input_a = tacho_reg;
	assign phase_input_b = cnt_reg[1];
	assign phase_input_c = cnt_reg[0];
endmodule
`default_nettype wire

// File: verification/sscs_props.sv
// Port-level checks of the sequencer.
`timescale 1ns/1ns
`default_nettype none
module sscs_props (
	input wire logic clk, // Clock.
	input wire logic nrst, // Reset.
	input wire logic [4:0] addr, // Address.
	input wire logic [15:0] wdata, // Write data.
	input wire logic wr, // Write strobe.
	input wire logic rd, // Read strobe.
	input wire logic [15:0] rdata, // Read data.
	input wire logic [1:0] comparator_input_select, // Mux select.
	input wire logic digital_input_mode, // Pin mode.
	input wire logic [5:0] phase_out, // Drives.
	input wire logic commutate, // Commutation.
	input wire logic update_irq // Update.
);
	logic [7:0] phase_reg;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_reg <= 8'h00;
		end else if (wr && addr == 5'h02) begin
			phase_reg <= wdata[7:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ********
	// Assertions
	// ********
	a_read_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_select_follow: assert property (wr && addr == 5'h02 |=>
		comparator_input_select == $past(wdata[7:6])) else $error("select mismatch");
	a_mode_follow: assert property (wr && addr == 5'h03 |=>
		digital_input_mode == ($past(wdata[1:0]) != 2'h0)) else $error("mode mismatch");
	a_phase_readback: assert property (rd && addr == 5'h02 |=>
		rdata == {8'h00, phase_reg}) else $error("phase readback");
	a_unmapped_zero: assert property (rd && addr > 5'h13 |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_state_onehot: assert property (rd && addr == 5'h09 |=> $onehot(rdata[3:0]))
		else $error("state not one-hot");
	a_commut_pulse: assert property (commutate |=> !commutate)
		else $error("commutation pulse too long");
	a_speed_quiet: assert property (digital_input_mode |-> !commutate)
		else $error("commutation in speed mode");
	a_no_shoot: assert property (!(phase_out[5] && phase_out[4]) &&
		!(phase_out[3] && phase_out[2]) && !(phase_out[1] && phase_out[0]))
		else $error("both switches of a leg on");
	c_commut: cover property (commutate);
	c_update: cover property (update_irq);
	c_speed: cover property ($rose(digital_input_mode));
endmodule
bind sscs_top sscs_props i_props (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
	.comparator_input_select, .digital_input_mode, .phase_out, .commutate, .update_irq);
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench of the commutation sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk, nrst, wr, rd, cmp_in, pa, pb, pc, commutate, update_irq, dim;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, rv, hp;
	logic [1:0] sel;
	logic [5:0] po, seen;
	int fails, comparisons, cyc, k;
	logic [7:0] ph [6] = '{8'hA1, 8'h64, 8'h09, 8'h86, 8'h52, 8'h18};
	logic [4:0] ra [8] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h0D, 5'h09, 5'h1F, 5'h0B};
	logic [15:0] rx [8] = '{16'h0080, 16'hFFFF, 16'hFFFF, 16'h00C8, 16'h0FFF, 16'h0001,
		16'h0000, 16'h0000};
	sscs_top i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .cmp_in(cmp_in), .phase_input_a(pa), .phase_input_b(pb),
		.phase_input_c(pc), .comparator_input_select(sel), .digital_input_mode(dim),
		.phase_out(po), .commutate(commutate), .update_irq(update_irq));
	sscs_motor_model i_motor (.clk(clk), .nrst(nrst), .phase_out(po), .half_period(hp),
		.cmp_in(cmp_in), .phase_input_a(pa), .phase_input_b(pb), .phase_input_c(pc));
	// ********
	// Tasks
	// ********
	task conclude();
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task wait_pulse(input int upd, input int lim);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while ((upd ? update_irq : commutate) !== 1'b1 && k < lim);
		chk({15'h0000, k < lim}, 16'h0001);
	endtask
	task observe(input logic [15:0] exp);
		seen = 6'h00;
		// The first cycles after an update still show the old duty through deadtime.
		repeat (4) @(negedge clk);
		repeat (32) begin
			@(negedge clk);
			seen = seen | po;
		end
		chk({10'h000, seen}, exp);
	endtask
	// ********
	// Clock, timeout and tests
	// ********
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 5'h00;
		wdata = 16'h0000;
		hp = 16'h0000;
		cyc = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		wr_reg(5'h1F, 16'hFFFF);
		wr_reg(5'h0B, 16'h1234);
		for (int i = 0; i < 8; i++) begin
			rd_reg(ra[i], rv);
			chk(rv, rx[i]);
		end
		for (int i = 0; i < 6; i++) begin
			wr_reg(5'h02, {8'h00, ph[i]});
			#1 chk({14'h0000, sel}, {14'h0000, ph[i][7:6]});
			rd_reg(5'h02, rv);
			chk(rv, {8'h00, ph[i]});
		end
		// Sensorless six-step run, software advancing the step at each commutation.
		wr_reg(5'h02, {8'h00, ph[0]});
		wr_reg(5'h01, 16'h0008);
		wr_reg(5'h07, 16'h0014);
		wr_reg(5'h0D, 16'h000F);
		wr_reg(5'h0F, 16'h0008);
		hp <= 16'h003C;
		wr_reg(5'h00, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			wait_pulse(0, 2000);
			rd_reg(5'h09, rv);
			chk({9'h000, rv[6:0]}, 16'h0072);
			wr_reg(5'h09, 16'h01F0);
			wr_reg(5'h02, {8'h00, ph[(i + 1) % 6]});
			wr_reg(5'h01, (i % 2) ? 16'h0008 : 16'h000D);
		end
		// Silent comparator, wide timer, no blanking: timer compares give both events.
		wr_reg(5'h00, 16'h0000);
		hp <= 16'h0000;
		wr_reg(5'h05, 16'h0030);
		wr_reg(5'h06, 16'h0040);
		wr_reg(5'h00, 16'h003B);
		wait_pulse(0, 1000);
		wait_pulse(0, 1000);
		// A software commutation forces demagnetization without a new zero crossing.
		wr_reg(5'h09, 16'h01F0);
		wr_reg(5'h13, 16'h0001);
		rd_reg(5'h09, rv);
		chk({9'h000, rv[6:0]}, 16'h0022);
		// Speed sensor mode on the digital phase pin.
		wr_reg(5'h00, 16'h0000);
		wr_reg(5'h03, 16'h0001);
		#1 chk({15'h0000, dim}, 16'h0001);
		hp <= 16'h0028;
		wr_reg(5'h00, 16'h0001);
		repeat (200) @(posedge clk);
		rd_reg(5'h09, rv);
		chk({15'h0000, rv[8]}, 16'h0001);
		rd_reg(5'h0A, rv);
		chk({15'h0000, rv < 16'h0060}, 16'h0001);
		// Sine mode: new preloads show only after an update.
		wr_reg(5'h00, 16'h0000);
		wr_reg(5'h03, 16'h0000);
		#1 chk({15'h0000, dim}, 16'h0000);
		wr_reg(5'h0D, 16'h001F);
		wr_reg(5'h12, 16'h0002);
		wr_reg(5'h0F, 16'h0000);
		wr_reg(5'h10, 16'h0020);
		wr_reg(5'h11, 16'h0010);
		wr_reg(5'h00, 16'h0005);
		wait_pulse(1, 200);
		observe(16'h0039);
		wr_reg(5'h0F, 16'h0020);
		wr_reg(5'h10, 16'h0000);
		wait_pulse(1, 200);
		observe(16'h0036);
		rd_reg(5'h09, rv);
		chk({15'h0000, rv[7]}, 16'h0001);
		conclude();
	end
endmodule
`default_nettype wire
